//--- include/csc_pkg.sv
// Constants, states and layouts for the clock synthesizer control slave.
// Assumes a two-wire serial master and one sampling clock on the link side.
// Function
// - A byte write is start, address with write bit, command, one data byte and stop, each byte acknowledged by the device.
// - A byte read is start, address, command, repeated start, address with read bit, one data byte back, master not-acknowledge, stop.
// - A command with its top bit set is a single-byte access and its bits one and zero index the control byte.
// - Control byte zero reads a fixed revision code in bits seven to four and a vendor code in bits three to zero.
// - Bits seven, five and four of control byte one enable the reference, USB and selectable audio clocks; zero holds them low.
// - Bit six of control byte one enables the spread processor clock; zero holds it low and shuts off its PLL.
// - Bit three of control byte one enables the fixed audio clock, is zero at power-up, and zero also turns off its PLL.
// - Bit zero of control byte one picks the higher audio rate when one and the lower when zero, and powers up at one.
// - Bits two to zero of control byte two pick the spread depth, unlisted codes give no spread, and the field powers up at 010.
// - The device answers only the address byte 11010010 with the read or write bit as its last bit.
// - A command with its top bit clear selects a block transfer starting from offset zero and moving upward; here such a command is left unanswered.
package csc_pkg;
  localparam logic [6:0] CSC_SLAVE_ADDR = 7'h69;
  localparam logic CSC_DIR_WRITE = 1'b0;
  localparam logic CSC_DIR_READ = 1'b1;
  localparam int CSC_CMD_SINGLE_BIT = 7;
  // Control byte indices
  localparam logic [1:0] CSC_IDX_ID = 2'h0;
  localparam logic [1:0] CSC_IDX_OUTPUT = 2'h1;
  localparam logic [1:0] CSC_IDX_SPREAD = 2'h2;
  // Byte one layout and power-up value
  localparam int CSC_BIT_REF_EN = 7;
  localparam int CSC_BIT_SPREAD_EN = 6;
  localparam int CSC_BIT_USB_EN = 5;
  localparam int CSC_BIT_SEL_AUDIO_EN = 4;
  localparam int CSC_BIT_FIX_AUDIO_EN = 3;
  localparam int CSC_BIT_RATE_SEL = 0;
  localparam logic [7:0] CSC_OUTPUT_RESET = 8'hf7;
  localparam logic [7:0] CSC_OUTPUT_WMASK = 8'hf9;
  // Byte two layout and power-up value
  localparam logic [7:0] CSC_SPREAD_RESET = 8'h02;
  localparam logic [7:0] CSC_SPREAD_WMASK = 8'h07;
  localparam int CSC_SPREAD_MSB = 2;
  // Spread depth codes and decoded depth
  localparam logic [2:0] CSC_SS_0P5 = 3'h1;
  localparam logic [2:0] CSC_SS_1P0 = 3'h2;
  localparam logic [2:0] CSC_SS_2P0 = 3'h4;
  localparam logic [2:0] CSC_SS_3P0 = 3'h6;
  localparam logic [1:0] CSC_DEPTH_0P5 = 2'h0;
  localparam logic [1:0] CSC_DEPTH_1P0 = 2'h1;
  localparam logic [1:0] CSC_DEPTH_2P0 = 2'h2;
  localparam logic [1:0] CSC_DEPTH_3P0 = 2'h3;
  localparam logic [2:0] CSC_LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    CSC_IDLE, CSC_ADDR, CSC_CMD, CSC_WDATA,
    CSC_ACK, CSC_RDATA, CSC_RACK, CSC_SKIP
  } csc_state_t;
endpackage

//--- rtl/csc_control.sv
// Serial control slave and control bytes of the clock synthesizer.
// Assumes scl and sda arrive unsynchronised from pins and link_clock
// oversamples them at several times the serial bit rate.
`timescale 1ns/1ps
`default_nettype none
module csc_control
  import csc_pkg::*;
#(
  parameter int unsigned REVISION_CODE = 5, // arbitrary value
  parameter int unsigned VENDOR_CODE = 6 // arbitrary value
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic link_clock,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic ref_clock_enable,
  output logic spread_processor_clock_enable,
  output logic spread_pll_enable,
  output logic usb_clock_enable,
  output logic selectable_audio_clock_enable,
  output logic fixed_audio_clock_enable,
  output logic fixed_audio_pll_enable,
  output logic audio_rate_select,
  output logic spread_on,
  output logic [1:0] spread_depth
);
  // Codes wider than their nibble cannot be served
  if (REVISION_CODE > 15 || VENDOR_CODE > 15) begin : g_bad_id
    $error("identification codes must fit in four bits");
  end
  localparam logic [7:0] ID_VALUE = {4'(REVISION_CODE), 4'(VENDOR_CODE)};

  // ---------------- link domain ----------------
  logic lrst_s1, lrst_s2;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  csc_state_t state_reg, ack_next_reg;
  logic [2:0] cnt_reg;
  logic [7:0] shift_reg, tx_reg, wr_data_reg;
  logic [1:0] idx_reg, wr_idx_reg;
  logic got_reg, oe_reg, rd_armed_reg, wr_tgl_reg, rd_tgl_reg;

  // Reset and pin synchronisers; logic reads the second stage, edge detection also the third
  always_ff @(posedge link_clock) begin
    lrst_s1 <= reset;
    lrst_s2 <= lrst_s1;
    scl_s1 <= scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_i;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end

  // Bus conditions seen on the synchronised pins
  wire start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
  wire stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;
  wire scl_rise = scl_s2 && !scl_d;
  wire scl_fall = !scl_s2 && scl_d;
  wire addr_match = shift_reg[7:1] == CSC_SLAVE_ADDR;
  wire addr_write = addr_match && shift_reg[0] == CSC_DIR_WRITE;
  wire addr_read = addr_match && shift_reg[0] == CSC_DIR_READ;
  wire cmd_single = shift_reg[CSC_CMD_SINGLE_BIT];
  logic [7:0] rd_hold_reg;

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_reg;

  // Serial protocol engine
  always_ff @(posedge link_clock) begin
    if (lrst_s2) begin
      state_reg <= CSC_IDLE;
      ack_next_reg <= CSC_IDLE;
      cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      idx_reg <= 2'h0;
      wr_idx_reg <= 2'h0;
      got_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_armed_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
    end else if (start_seen) begin
      // Start or repeated start always restarts address capture
      state_reg <= CSC_ADDR;
      cnt_reg <= 3'h0;
      got_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (stop_seen) begin
      state_reg <= CSC_IDLE;
      oe_reg <= 1'b0;
      rd_armed_reg <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        CSC_ADDR, CSC_CMD, CSC_WDATA: begin
          shift_reg <= {shift_reg[6:0], sda_s2};
          cnt_reg <= cnt_reg + 3'h1;
          got_reg <= cnt_reg == CSC_LAST_BIT;
        end
        CSC_RACK: state_reg <= CSC_SKIP;
        CSC_IDLE, CSC_ACK, CSC_RDATA, CSC_SKIP: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        CSC_ADDR: begin
          if (got_reg) begin
            got_reg <= 1'b0;
            if (addr_write) begin
              oe_reg <= 1'b1;
              ack_next_reg <= CSC_CMD;
              state_reg <= CSC_ACK;
            end else if (addr_read && rd_armed_reg) begin
              oe_reg <= 1'b1;
              ack_next_reg <= CSC_RDATA;
              state_reg <= CSC_ACK;
            end else begin
              state_reg <= CSC_SKIP;
            end
          end
        end
        CSC_CMD: begin
          if (got_reg) begin
            got_reg <= 1'b0;
            if (cmd_single) begin
              idx_reg <= shift_reg[1:0];
              rd_tgl_reg <= !rd_tgl_reg;
              rd_armed_reg <= 1'b1;
              oe_reg <= 1'b1;
              ack_next_reg <= CSC_WDATA;
              state_reg <= CSC_ACK;
            end else begin
              // Block transfers are not served and left unanswered
              state_reg <= CSC_SKIP;
            end
          end
        end
        CSC_WDATA: begin
          if (got_reg) begin
            got_reg <= 1'b0;
            wr_data_reg <= shift_reg;
            wr_idx_reg <= idx_reg;
            wr_tgl_reg <= !wr_tgl_reg;
            rd_armed_reg <= 1'b0;
            oe_reg <= 1'b1;
            ack_next_reg <= CSC_SKIP;
            state_reg <= CSC_ACK;
          end
        end
        CSC_ACK: begin
          cnt_reg <= 3'h0;
          state_reg <= ack_next_reg;
          if (ack_next_reg == CSC_RDATA) begin
            // First data bit goes out as the acknowledge ends
            oe_reg <= !rd_hold_reg[7];
            tx_reg <= {rd_hold_reg[6:0], 1'b0};
          end else begin
            oe_reg <= 1'b0;
          end
        end
        CSC_RDATA: begin
          if (cnt_reg == CSC_LAST_BIT) begin
            oe_reg <= 1'b0;
            state_reg <= CSC_RACK;
          end else begin
            oe_reg <= !tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        CSC_IDLE, CSC_RACK, CSC_SKIP: ;
      endcase
    end
  end

  // ---------------- system domain ----------------
  logic wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;
  logic [7:0] output_reg, spread_reg;

  // Toggle crossings; held words are written with each toggle and stable before each pulse
  always_ff @(posedge clock) begin
    wr_s1 <= wr_tgl_reg;
    wr_s2 <= wr_s1;
    wr_s3 <= wr_s2;
    rd_s1 <= rd_tgl_reg;
    rd_s2 <= rd_s1;
    rd_s3 <= rd_s2;
  end

  wire wr_pulse = wr_s2 ^ wr_s3;
  wire rd_pulse = rd_s2 ^ rd_s3;
  wire wr_output = wr_pulse && wr_idx_reg == CSC_IDX_OUTPUT;
  wire wr_spread = wr_pulse && wr_idx_reg == CSC_IDX_SPREAD;
  // Reserved bits are kept from the power-up value, never from the bus
  wire [7:0] output_next = (wr_data_reg & CSC_OUTPUT_WMASK)
                         | (CSC_OUTPUT_RESET & ~CSC_OUTPUT_WMASK);
  wire [7:0] spread_next = (wr_data_reg & CSC_SPREAD_WMASK)
                         | (CSC_SPREAD_RESET & ~CSC_SPREAD_WMASK);
  logic [7:0] rd_sel;
  always_comb begin
    unique case (idx_reg)
      CSC_IDX_ID: rd_sel = ID_VALUE;
      CSC_IDX_OUTPUT: rd_sel = output_reg;
      CSC_IDX_SPREAD: rd_sel = spread_reg;
      default: rd_sel = 8'h00; // Unused index reads zero
    endcase
  end

  // Control bytes; byte zero has no storage and ignores writes
  always_ff @(posedge clock) begin
    if (reset) begin
      output_reg <= CSC_OUTPUT_RESET;
      spread_reg <= CSC_SPREAD_RESET;
      rd_hold_reg <= 8'h00;
    end else begin
      if (wr_output) output_reg <= output_next;
      if (wr_spread) spread_reg <= spread_next;
      if (rd_pulse) rd_hold_reg <= rd_sel;
    end
  end

  // Clock and PLL controls follow the stored bits directly
  assign ref_clock_enable = output_reg[CSC_BIT_REF_EN];
  assign usb_clock_enable = output_reg[CSC_BIT_USB_EN];
  assign selectable_audio_clock_enable = output_reg[CSC_BIT_SEL_AUDIO_EN];
  assign spread_processor_clock_enable = output_reg[CSC_BIT_SPREAD_EN];
  assign spread_pll_enable = output_reg[CSC_BIT_SPREAD_EN];
  assign fixed_audio_clock_enable = output_reg[CSC_BIT_FIX_AUDIO_EN];
  assign fixed_audio_pll_enable = output_reg[CSC_BIT_FIX_AUDIO_EN];
  assign audio_rate_select = output_reg[CSC_BIT_RATE_SEL];

  // Spread depth decode; four codes mean no spread
  wire [2:0] ss_code = spread_reg[CSC_SPREAD_MSB:0];
  always_comb begin
    spread_on = 1'b1;
    spread_depth = CSC_DEPTH_0P5;
    unique case (ss_code)
      CSC_SS_0P5: spread_depth = CSC_DEPTH_0P5;
      CSC_SS_1P0: spread_depth = CSC_DEPTH_1P0;
      CSC_SS_2P0: spread_depth = CSC_DEPTH_2P0;
      CSC_SS_3P0: spread_depth = CSC_DEPTH_3P0;
      default: spread_on = 1'b0;
    endcase
  end

  // ---------------- checks ----------------
  a_ctrl_write_lands: assert property (
    @(posedge clock) disable iff (reset)
    wr_output |=> output_reg == $past(output_next))
    else $error("control byte one did not take the write");

  a_reserved_bits_kept: assert property (
    @(posedge clock) disable iff (reset)
    (output_reg & ~CSC_OUTPUT_WMASK) == 8'h06
    && spread_reg[7:3] == 5'h00)
    else $error("reserved bits moved");

  a_spread_pll_off: assert property (
    @(posedge clock) disable iff (reset)
    wr_output && !wr_data_reg[CSC_BIT_SPREAD_EN]
    |=> !spread_pll_enable && !spread_processor_clock_enable)
    else $error("spread clock PLL not shut off");

  a_fixed_audio_off: assert property (
    @(posedge clock) disable iff (reset)
    wr_output && !wr_data_reg[CSC_BIT_FIX_AUDIO_EN]
    |=> !fixed_audio_pll_enable)
    else $error("fixed audio PLL not turned off");

  a_rate_follows: assert property (
    @(posedge clock) disable iff (reset)
    wr_output |=> audio_rate_select == $past(wr_data_reg[0]))
    else $error("audio rate select did not follow");

  a_no_spread_codes: assert property (
    @(posedge clock) disable iff (reset)
    wr_spread && wr_data_reg[1:0] == 2'h3 |=> !spread_on)
    else $error("spread enabled on a no-spread code");

  a_id_read_value: assert property (
    @(posedge clock) disable iff (reset)
    rd_pulse && idx_reg == CSC_IDX_ID |=> rd_hold_reg == ID_VALUE)
    else $error("identification byte wrong");

  a_addr_acked: assert property (
    @(posedge link_clock) disable iff (lrst_s2)
    state_reg == CSC_ADDR && got_reg && scl_fall && !start_seen
    && !stop_seen |=> oe_reg == (addr_write || $past(addr_read
    && rd_armed_reg)))
    else $error("address acknowledge wrong");

  a_cmd_index_taken: assert property (
    @(posedge link_clock) disable iff (lrst_s2)
    state_reg == CSC_CMD && got_reg && scl_fall && cmd_single
    && !start_seen && !stop_seen
    |=> idx_reg == $past(shift_reg[1:0]) && state_reg == CSC_ACK)
    else $error("command index not taken");

  a_block_refused: assert property (
    @(posedge link_clock) disable iff (lrst_s2)
    state_reg == CSC_CMD && got_reg && scl_fall && !cmd_single
    && !start_seen && !stop_seen |=> state_reg == CSC_SKIP && !oe_reg)
    else $error("block command answered");

  a_read_released: assert property (
    @(posedge link_clock) disable iff (lrst_s2)
    state_reg == CSC_RDATA && scl_fall && cnt_reg == CSC_LAST_BIT
    && !start_seen && !stop_seen |=> !oe_reg && state_reg == CSC_RACK)
    else $error("line not released after read byte");

  a_data_byte_acked: assert property (
    @(posedge link_clock) disable iff (lrst_s2)
    state_reg == CSC_WDATA && got_reg && scl_fall && !start_seen
    && !stop_seen |=> oe_reg && wr_tgl_reg != $past(wr_tgl_reg))
    else $error("data byte not acknowledged");
endmodule
`default_nettype wire

//--- testbench/csc_control_bench.sv
// Self-checking bench for the clock synthesizer control slave.
// Assumes the master model in its own file and a pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module csc_control_bench;
  import csc_pkg::*;
  localparam int TIMEOUT = 60000;
  logic clock, reset, link_clock, scl, sda_low, sda_o, sda_oe;
  logic ref_en, sp_en, sp_pll, usb_en, sel_en, fix_en, fix_pll, rate_sel;
  logic spread_on;
  logic [1:0] spread_depth;
  logic [2:0] acks;
  logic [7:0] rd;
  int failures, check_count, cycles;
  logic [7:0] wr_vals [4] = '{8'h00, 8'h88, 8'h51, 8'hff};
  logic [7:0] id_vals [3] = '{8'h56, 8'hf7, 8'h02};

  // Open drain: low if anyone pulls, else the pull-up wins
  wire sda = ~((sda_oe & ~sda_o) | sda_low);
  wire [7:0] out1 = {ref_en, sp_en, usb_en, sel_en, fix_en, sp_pll,
                     fix_pll, rate_sel};
  wire [7:0] spr = {5'h00, spread_on, spread_depth};

  // System clock, then a link clock of unrelated phase
  initial clock = 1'b0;
  always #50 clock = ~clock;
  initial begin
    link_clock = 1'b0;
    #17;
    forever #62.5 link_clock = ~link_clock;
  end

  csc_control dut (.clock(clock), .reset(reset), .link_clock(link_clock),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .ref_clock_enable(ref_en), .spread_processor_clock_enable(sp_en),
    .spread_pll_enable(sp_pll), .usb_clock_enable(usb_en),
    .selectable_audio_clock_enable(sel_en),
    .fixed_audio_clock_enable(fix_en), .fixed_audio_pll_enable(fix_pll),
    .audio_rate_select(rate_sel), .spread_on(spread_on),
    .spread_depth(spread_depth));

  csc_master_model master (.clock(clock), .sda(sda), .scl(scl),
    .sda_low(sda_low));

  // Output pins expected from a control byte one value
  function automatic logic [7:0] out1_exp(input logic [7:0] v);
    return {v[7], v[6], v[5], v[4], v[3], v[6], v[3], v[0]};
  endfunction

  // Spread flag and depth expected from a depth code
  function automatic logic [7:0] spread_exp(input logic [2:0] c);
    case (c)
      3'h1: return 8'h04;
      3'h2: return 8'h05;
      3'h4: return 8'h06;
      3'h6: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard; the full sequence needs roughly half of this
  always @(posedge clock) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    reset = 1'b1;
    failures = 0;
    check_count = 0;
    cycles = 0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    // Power-up values at the pins and through reads
    check(out1, out1_exp(8'hf7));
    check(spr, spread_exp(3'h2));
    for (int i = 0; i < 3; i++) begin
      master.read_txn(8'hd2, 8'h80 | 8'(i), rd, acks);
      check({5'h00, acks}, 8'h07);
      check(rd, id_vals[i]);
    end
    // Byte one writes; spare command bits must not matter
    foreach (wr_vals[i]) begin
      master.write_txn(8'hd2, 8'hfd, wr_vals[i], acks);
      repeat (6) @(negedge clock);
      check({5'h00, acks}, 8'h07);
      check(out1, out1_exp(wr_vals[i]));
      master.read_txn(8'hd2, 8'h81, rd, acks);
      check(rd, (wr_vals[i] & 8'hf9) | 8'h06);
    end
    // Every spread code, with some reserved upper bits set
    for (int c = 0; c < 8; c++) begin
      master.write_txn(8'hd2, 8'h82, {5'h15, 3'(c)}, acks);
      repeat (6) @(negedge clock);
      check(spr, spread_exp(3'(c)));
      master.read_txn(8'hd2, 8'h82, rd, acks);
      check(rd, {5'h00, 3'(c)});
    end
    // Foreign address: nothing answered, nothing changed
    master.write_txn(8'hd4, 8'h81, 8'h00, acks);
    repeat (6) @(negedge clock);
    check({5'h00, acks}, 8'h00);
    check(out1, out1_exp(8'hff));
    // Block command refused after the address answer
    master.write_txn(8'hd2, 8'h00, 8'h00, acks);
    repeat (6) @(negedge clock);
    check({5'h00, acks}, 8'h04);
    check(out1, out1_exp(8'hff));
    // Identification byte cannot be written
    master.write_txn(8'hd2, 8'h80, 8'h00, acks);
    master.read_txn(8'hd2, 8'hfc, rd, acks);
    check(rd, 8'h56);
    master.read_txn(8'hd2, 8'he2, rd, acks);
    check(rd, 8'h07);
    // Unused index: write answered but dropped, read gives zero
    master.write_txn(8'hd2, 8'h83, 8'hff, acks);
    repeat (6) @(negedge clock);
    check({5'h00, acks}, 8'h07);
    check(spr, spread_exp(3'h7));
    check(out1, out1_exp(8'hff));
    master.read_txn(8'hd2, 8'h83, rd, acks);
    check(rd, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- testbench/csc_master_model.sv
// Two-wire bus master standing in for the system controller.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module csc_master_model #(
  parameter int QUARTER = 6
) (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Bus idles released, both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter bit time; keeps each clock phase above four link cycles
  task automatic wait_q(input int n);
    repeat (n * QUARTER) @(negedge clock);
  endtask

  // Start, or repeated start from a low serial clock
  task automatic bus_start();
    sda_low = 1'b0;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    sda_low = 1'b1;
    wait_q(1);
    scl = 1'b0;
  endtask

  // Data rises while the clock is high
  task automatic bus_stop();
    sda_low = 1'b1;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    sda_low = 1'b0;
    wait_q(2);
  endtask

  // Data set mid-low, sampled mid-high, held a quarter past the fall
  task automatic bus_bit(input logic b, output logic seen);
    wait_q(1);
    sda_low = ~b;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    seen = sda;
    wait_q(1);
    scl = 1'b0;
  endtask

  // Eight bits most significant first, then the answer bit
  task automatic bus_byte(input logic [7:0] tx, input logic ack_bit,
                          output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(tx[i], s);
      rx[i] = s;
    end
    bus_bit(ack_bit, s);
    ack = ~s;
  endtask

  // Byte write; acks holds address, command and data answers
  task automatic write_txn(input logic [7:0] adr, cmd, dat,
                           output logic [2:0] acks);
    logic [7:0] rx;
    bus_start();
    bus_byte(adr, 1'b1, rx, acks[2]);
    bus_byte(cmd, 1'b1, rx, acks[1]);
    bus_byte(dat, 1'b1, rx, acks[0]);
    bus_stop();
  endtask

  // Byte read; the data byte is refused with not-acknowledge
  task automatic read_txn(input logic [7:0] adr, cmd,
                          output logic [7:0] dat, output logic [2:0] acks);
    logic nack;
    bus_start();
    bus_byte(adr, 1'b1, dat, acks[2]);
    bus_byte(cmd, 1'b1, dat, acks[1]);
    bus_start();
    bus_byte(adr | 8'h01, 1'b1, dat, acks[0]);
    bus_byte(8'hff, 1'b1, dat, nack);
    bus_stop();
  endtask
endmodule
`default_nettype wire
